// File: rtl/dce_pkg.sv
/*
 dce_pkg: register map, control field positions, reset values and
 sizes shared by the checksum engine and its word fifo.
 assumes 32-bit apb data and byte addresses on an 8-bit offset.
*/
package dce_pkg;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] DATA_OFF = 8'h04;
    localparam logic [7:0] XOR_OFF = 8'h08;
    localparam logic [7:0] ADDR_OFF = 8'h0c;
    localparam int ORDER_LSB = 28;
    localparam int REORDER_BIT = 27;
    localparam int REFLECT_BIT = 24;
    localparam int LEN_LSB = 8;
    localparam int EN_BIT = 7;
    localparam int APP_BIT = 6;
    localparam int TYP_BIT = 5;
    localparam int CH_LSB = 0;
    localparam logic [31:0] CTRL_MASK = 32'h3900_1fe7;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [31:0] XOR_RST = 32'h0000_0000;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam int WORD_W = 32;
    localparam int CH_W = 3;
    localparam int FIFO_DEPTH = 32;
    localparam int BEAT_W = 2 * WORD_W + CH_W;
endpackage

// File: rtl/dce_fifo.sv
/*
 dce_fifo: flip-flop fifo with valid and ready on both sides.
 assumes DEPTH is a power of two; one clock, async active-low reset.
*/
module dce_fifo #(
    parameter int WIDTH = dce_pkg::BEAT_W,
    parameter int DEPTH = dce_pkg::FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, push, pop;

    assign push = in_valid && rdy_q;
    assign pop = out_valid && out_ready;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign in_ready = rdy_q;

    always_comb begin
        wr_d = push ? wr_q + AW'(1) : wr_q;
        rd_d = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
        // registered ready keeps the source path free of the pop logic
        rdy_d = cnt_d != FULL;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// File: rtl/dce_engine.sv
/*
 dce_engine: apb registers, lfsr crc / ip checksum datapath for dma beats.
 assumes dma logic on pclk: beats carry data, channel and destination
 address; blk_done pulses once per finished block with its channel.
*/
// Implementation choices: the APB interface to the registers and the placing of the registers.
// What this block does
// - read-only word tracks the bus address of the latest dma access
// - byte order field: keep, reverse word, swap halves, reverse in halves
// - write reorder set writes destination in selected byte order
// - bit order set feeds data lsb first, else msb first
// - lfsr length is field plus one; ignored in ip header mode
// - enable routes selected channel through engine, else untouched
// - append mode feeds crc only, then writes result to dest start
// - append off: data goes through crc and on to destination
// - write reorder set keeps append mode from being set
// - type bit picks ip header checksum when set, lfsr otherwise
// - three-bit field picks which of eight channels uses the engine
// - unimplemented control bits read zero and ignore writes
// - data write seeds, read returns crc, bits above length zero
// - ip mode: low 16 bits in ones' complement, upper bits zero
// - tap enable bits 31:1 add feedback xor into their stage; stage 0 always takes feedback, bit 0 unused
module dce_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [dce_pkg::WORD_W-1:0] pwdata,
    output logic [dce_pkg::WORD_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dma_acc_valid,
    input wire logic [dce_pkg::WORD_W-1:0] dma_acc_addr,
    input wire logic src_valid,
    output logic src_ready,
    input wire logic [dce_pkg::WORD_W-1:0] src_data,
    input wire logic [dce_pkg::WORD_W-1:0] src_dst_addr,
    input wire logic [dce_pkg::CH_W-1:0] src_chan,
    input wire logic blk_done,
    input wire logic [dce_pkg::CH_W-1:0] blk_chan,
    input wire logic [dce_pkg::WORD_W-1:0] channel_dest_start_address,
    output logic dst_valid,
    input wire logic dst_ready,
    output logic [dce_pkg::WORD_W-1:0] dst_data,
    output logic [dce_pkg::WORD_W-1:0] dst_addr
);
    import dce_pkg::*;

    function automatic logic [31:0] reorder(logic [31:0] d, logic [1:0] sel);
        unique case (sel)
            2'b00: reorder = d;
            2'b01: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
            2'b10: reorder = {d[15:0], d[31:16]};
            2'b11: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
        endcase
    endfunction

    function automatic logic [31:0] len_mask(logic [4:0] lm1);
        len_mask = 32'hffff_ffff >> (5'd31 - lm1);
    endfunction

    function automatic logic [31:0] lfsr(logic [31:0] c, logic [31:0] d,
                                         logic [31:0] taps, logic [4:0] lm1,
                                         logic refl);
        logic [31:0] n;
        logic fb;
        n = c;
        for (int k = 0; k < 32; k++) begin
            fb = n[lm1] ^ (refl ? d[k] : d[31-k]);
            for (int i = 31; i > 0; i--) begin
                n[i] = n[i-1] ^ (fb & taps[i]);
            end
            n[0] = fb;
        end
        lfsr = n & len_mask(lm1);
    endfunction

    function automatic logic [15:0] oc_add(logic [15:0] a, logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        oc_add = t[15:0] + {15'h0000, t[16]};
    endfunction

    function automatic logic [15:0] rev16(logic [15:0] h);
        for (int i = 0; i < 16; i++) begin
            rev16[i] = h[15-i];
        end
    endfunction

    function automatic logic [15:0] ip_sum(logic [15:0] s, logic [31:0] d, logic refl);
        logic [15:0] hi, lo;
        hi = refl ? rev16(d[31:16]) : d[31:16];
        lo = refl ? rev16(d[15:0]) : d[15:0];
        ip_sum = oc_add(oc_add(s, hi), lo);
    endfunction

    logic [31:0] ctrl_q, ctrl_d, crc_q, crc_d, taps_q, taps_d;
    logic [31:0] last_q, last_d, prdata_q, prdata_d;
    logic [31:0] dst_data_q, dst_data_d, dst_addr_q, dst_addr_d, dsa_q, dsa_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic dst_valid_q, dst_valid_d, pend_q, pend_d;
    logic f_valid, f_pop, out_free, thr, app, ip, wr_en, setup, fire;
    logic [BEAT_W-1:0] f_data;
    logic [31:0] f_word, f_addr, word_in, crc_view, crc_rd;
    logic [CH_W-1:0] f_chan;
    logic [4:0] len_m1;

    dce_fifo #(
        .WIDTH(BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .in_data({src_dst_addr, src_data, src_chan}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    assign {f_addr, f_word, f_chan} = f_data;
    assign len_m1 = ctrl_q[LEN_LSB +: 5];
    assign ip = ctrl_q[TYP_BIT];
    assign app = ctrl_q[APP_BIT];
    assign thr = ctrl_q[EN_BIT] && (f_chan == ctrl_q[CH_LSB +: CH_W]);
    assign out_free = !dst_valid_q || dst_ready;
    // result waits for an empty fifo; queued words are not popped while it is pending
    assign fire = pend_q && !f_valid && out_free;
    assign f_pop = f_valid && out_free && !pend_q;
    assign word_in = reorder(f_word, ctrl_q[ORDER_LSB +: 2]);
    assign crc_rd = ip ? {16'h0000, ~crc_q[15:0]} : (crc_q & len_mask(len_m1));
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite;

    always_comb begin
        ctrl_d = ctrl_q;
        crc_d = crc_q;
        taps_d = taps_q;
        last_d = dma_acc_valid ? dma_acc_addr : last_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = setup; // zero-wait answer in the first access cycle
        dst_valid_d = dst_valid_q && !dst_ready;
        dst_data_d = dst_data_q;
        dst_addr_d = dst_addr_q;
        dsa_d = dsa_q;
        pend_d = pend_q && !fire;
        if (f_pop) begin
            if (thr) begin
                crc_view = ip ? {16'h0000, ip_sum(crc_q[15:0], word_in, ctrl_q[REFLECT_BIT])}
                              : lfsr(crc_q, word_in, taps_q, len_m1, ctrl_q[REFLECT_BIT]);
                crc_d = crc_view;
            end else begin
                crc_view = crc_q;
            end
            if (!(thr && app)) begin
                dst_valid_d = 1'b1;
                dst_data_d = (thr && ctrl_q[REORDER_BIT]) ? word_in : f_word;
                dst_addr_d = f_addr;
            end
        end else begin
            crc_view = crc_q;
        end
        if (fire) begin
            dst_valid_d = 1'b1;
            dst_data_d = crc_rd;
            dst_addr_d = dsa_q;
        end
        // a new completion outranks the clear of the pending one
        if (blk_done && ctrl_q[EN_BIT] && app && blk_chan == ctrl_q[CH_LSB +: CH_W]) begin
            pend_d = 1'b1;
            dsa_d = channel_dest_start_address;
        end
        if (setup) begin
            unique case (paddr)
                CTRL_OFF: prdata_d = ctrl_q;
                DATA_OFF: prdata_d = crc_rd;
                XOR_OFF: prdata_d = taps_q;
                ADDR_OFF: prdata_d = last_q;
                default: begin
                    prdata_d = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (wr_en) begin
            unique case (paddr)
                CTRL_OFF: begin
                    ctrl_d = pwdata & CTRL_MASK;
                    if (pwdata[REORDER_BIT]) begin
                        ctrl_d[APP_BIT] = 1'b0;
                    end
                end
                DATA_OFF: crc_d = ip ? {16'h0000, ~pwdata[15:0]} : pwdata;
                XOR_OFF: taps_d = pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            crc_q <= DATA_RST;
            taps_q <= XOR_RST;
            last_q <= ADDR_RST;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            dst_valid_q <= 1'b0;
            dst_data_q <= 32'h0000_0000;
            dst_addr_q <= 32'h0000_0000;
            dsa_q <= 32'h0000_0000;
            pend_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            crc_q <= crc_d;
            taps_q <= taps_d;
            last_q <= last_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            dst_valid_q <= dst_valid_d;
            dst_data_q <= dst_data_d;
            dst_addr_q <= dst_addr_d;
            dsa_q <= dsa_d;
            pend_q <= pend_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dst_valid = dst_valid_q;
    assign dst_data = dst_data_q;
    assign dst_addr = dst_addr_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_addr_track: assert property (
        dma_acc_valid |=> last_q == $past(dma_acc_addr))
        else $error("last access address not captured");
    a_ctrl_reserved: assert property (
        (ctrl_q & ~CTRL_MASK) == 32'h0000_0000)
        else $error("reserved control bit set");
    a_no_app_reorder: assert property (
        wr_en && paddr == CTRL_OFF && pwdata[REORDER_BIT] |=> !ctrl_q[APP_BIT])
        else $error("append set with write reorder");
    a_app_no_write: assert property (
        f_pop && thr && app |=> !dst_valid_q)
        else $error("append mode wrote source data");
    a_plain_write: assert property (
        f_pop && thr && !app && !ctrl_q[REORDER_BIT]
        |=> dst_valid_q && dst_data_q == $past(f_word) && dst_addr_q == $past(f_addr))
        else $error("destination data altered without reorder");
    a_bypass_crc: assert property (
        f_pop && !thr && !wr_en |=> $stable(crc_q) && dst_data_q == $past(f_word))
        else $error("bypass beat touched the crc");
    a_len_mask: assert property (
        setup && paddr == DATA_OFF && !ip
        |=> (prdata_q & ~len_mask($past(len_m1))) == 32'h0000_0000)
        else $error("crc read above polynomial length");
    a_ip_upper: assert property (
        setup && paddr == DATA_OFF && ip |=> prdata_q[31:16] == 16'h0000)
        else $error("ip checksum upper half not zero");
    a_dst_hold: assert property (
        dst_valid_q && !dst_ready |=> dst_valid_q && $stable(dst_data_q) && $stable(dst_addr_q))
        else $error("destination beat dropped under back-pressure");
    // a reorder write clears append, so only plain writes store the masked word
    a_ctrl_write: assert property (
        wr_en && paddr == CTRL_OFF && !pwdata[REORDER_BIT]
        |=> ctrl_q == ($past(pwdata) & CTRL_MASK))
        else $error("control write not stored through mask");
    a_seed_lfsr: assert property (
        wr_en && paddr == DATA_OFF && !ip |=> crc_q == $past(pwdata))
        else $error("lfsr seed not taken");
    a_seed_ip: assert property (
        wr_en && paddr == DATA_OFF && ip |=> crc_q == {16'h0000, ~$past(pwdata[15:0])})
        else $error("ip seed not stored as complement");
    a_tap_write: assert property (
        wr_en && paddr == XOR_OFF |=> taps_q == $past(pwdata))
        else $error("tap enable write lost");
    a_ip_high_zero: assert property (
        f_pop && thr && ip |=> crc_q[31:16] == 16'h0000)
        else $error("ip checksum grew above 16 bits");
    a_reorder_bytes: assert property (
        f_pop && thr && !app && ctrl_q[REORDER_BIT] && ctrl_q[ORDER_LSB +: 2] == 2'b01
        |=> dst_data_q == {$past(f_word[7:0]), $past(f_word[15:8]),
                           $past(f_word[23:16]), $past(f_word[31:24])})
        else $error("destination bytes not reversed");
    a_beat_addr: assert property (
        f_pop && !(thr && app) |=> dst_valid_q && dst_addr_q == $past(f_addr))
        else $error("destination beat address wrong");
    a_pend_take: assert property (
        blk_done && ctrl_q[EN_BIT] && app && blk_chan == ctrl_q[CH_LSB +: CH_W]
        |=> pend_q && dsa_q == $past(channel_dest_start_address))
        else $error("block completion not captured");
    a_result_addr: assert property (
        fire |=> dst_valid_q && dst_addr_q == $past(dsa_q))
        else $error("result not sent to start address");
    a_other_chan: assert property (
        blk_done && blk_chan != ctrl_q[CH_LSB +: CH_W] && !pend_q |=> !pend_q)
        else $error("completion of another channel taken");
endmodule

// File: bench/dce_dma_model.sv
/*
 dce_dma_model: dma channel side of the engine; sends beats, access
 addresses and block completions, and takes destination writes.
 assumes callers enter its tasks just after a rising pclk edge.
*/
module dce_dma_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    output logic dma_acc_valid,
    output logic [31:0] dma_acc_addr,
    output logic src_valid,
    input wire logic src_ready,
    output logic [31:0] src_data,
    output logic [31:0] src_dst_addr,
    output logic [2:0] src_chan,
    output logic blk_done,
    output logic [2:0] blk_chan,
    output logic [31:0] channel_dest_start_address,
    input wire logic dst_valid,
    output logic dst_ready,
    input wire logic [31:0] dst_data,
    input wire logic [31:0] dst_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] got_q[$];
    initial begin
        {dma_acc_valid, src_valid, blk_done} = 3'h0;
        {dma_acc_addr, src_data, src_dst_addr, channel_dest_start_address} = '1;
        src_chan = 3'h0;
        blk_chan = 3'h0;
    end
    // stall holds the sink so the fifo can be filled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) dst_ready <= 1'b0;
        else dst_ready <= !stall;
    end
    always @(posedge pclk) begin
        if (dst_valid && dst_ready) got_q.push_back({dst_addr, dst_data});
    end
    // valid stays up between beats; idle drops it
    task automatic send(input logic [31:0] d, input logic [31:0] a, input logic [2:0] c);
        src_valid <= 1'b1;
        src_data <= d;
        src_dst_addr <= a;
        src_chan <= c;
        dma_acc_valid <= 1'b1;
        dma_acc_addr <= a;
        @(posedge pclk);
        while (!src_ready) @(posedge pclk);
    endtask
    // released lines show the inverse, never a stale copy
    task automatic idle();
        src_valid <= 1'b0;
        dma_acc_valid <= 1'b0;
        src_data <= ~src_data;
        src_dst_addr <= ~src_dst_addr;
        src_chan <= ~src_chan;
        dma_acc_addr <= ~dma_acc_addr;
    endtask
    task automatic blk(input logic [2:0] c, input logic [31:0] a);
        blk_done <= 1'b1;
        blk_chan <= c;
        channel_dest_start_address <= a;
        @(posedge pclk);
        blk_done <= 1'b0;
        channel_dest_start_address <= ~a;
        // one low edge so a following call never re-raises in the same step
        @(posedge pclk);
    endtask
endmodule

// File: bench/tb.sv
/*
 tb: self-checking bench for dce_engine with an apb master and the
 dma model; crc expectations come from a reference crc in this file.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dce_pkg::*;
    typedef struct {logic [31:0] ctl; logic [2:0] ch; logic [31:0] dst;} dce_row_t;
    localparam logic [31:0] TAP = 32'h04c1_1db7;
    localparam logic [31:0] SEED = 32'hffff_ffff;
    localparam logic [31:0] DIN = 32'h1122_3344;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, e;
    logic dav, sv, sr, bd, dv, dr;
    logic [31:0] daa, sd, sa, csa, dd, da;
    logic [2:0] sc, bc;
    int err_count, compares;
    dce_row_t rows[11] = '{'{32'h0000_1f82, 3'h2, 32'h1122_3344},
        '{32'h1800_1f82, 3'h2, 32'h4433_2211}, '{32'h2800_1f82, 3'h2, 32'h3344_1122},
        '{32'h3800_1f82, 3'h2, 32'h2211_4433}, '{32'h3000_1f82, 3'h2, 32'h1122_3344},
        '{32'h0100_0f82, 3'h2, 32'h1122_3344}, '{32'h0000_00a2, 3'h2, 32'h1122_3344},
        '{32'h0000_1f02, 3'h2, 32'h1122_3344}, '{32'h0000_1f83, 3'h2, 32'h1122_3344},
        '{32'h0000_1f87, 3'h7, 32'h1122_3344}, '{32'h0100_00a2, 3'h2, 32'h1122_3344}};
    dce_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_acc_valid(dav), .dma_acc_addr(daa), .src_valid(sv),
        .src_ready(sr), .src_data(sd), .src_dst_addr(sa), .src_chan(sc), .blk_done(bd),
        .blk_chan(bc), .channel_dest_start_address(csa), .dst_valid(dv), .dst_ready(dr),
        .dst_data(dd), .dst_addr(da));
    dce_dma_model m (.pclk(pclk), .presetn(presetn), .stall(stall), .dma_acc_valid(dav),
        .dma_acc_addr(daa), .src_valid(sv), .src_ready(sr), .src_data(sd), .src_dst_addr(sa),
        .src_chan(sc), .blk_done(bd), .blk_chan(bc), .channel_dest_start_address(csa),
        .dst_valid(dv), .dst_ready(dr), .dst_data(dd), .dst_addr(da));
    always #5 pclk = ~pclk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_dst(input int n);
        for (int k = 0; k < 100 && m.got_q.size() < n; k++) @(posedge pclk);
        chk(64'(m.got_q.size()), 64'(n));
    endtask
    function automatic logic [31:0] bo(logic [31:0] d, logic [1:0] s);
        case (s)
            2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
            2'h2: return {d[15:0], d[31:16]};
            2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
            default: return d;
        endcase
    endfunction
    function automatic logic [31:0] exp_crc(logic [31:0] c, logic [2:0] ch, logic [31:0] s,
                                            logic [31:0] d);
        logic [16:0] t;
        logic fb;
        logic eng;
        int n;
        logic [31:0] r;
        n = c[12:8] + 1;
        eng = c[7] && c[2:0] == ch;
        d = bo(d, c[29:28]);
        for (int b = 0; b < 32; b++) r[b] = d[(b & 16) + 15 - (b & 15)];
        if (c[5]) begin
            if (c[24]) d = r;
            t = {1'b0, ~s[15:0]};
            for (int h = 1; h >= 0 && eng; h--) begin
                t = t + d[16*h+:16];
                t = t[15:0] + t[16];
            end
            return {16'h0, ~t[15:0]};
        end
        for (int i = 0; i < 32 && eng; i++) begin
            fb = s[n-1] ^ (c[24] ? d[i] : d[31-i]);
            s = (s << 1) ^ (TAP & {32{fb}});
            s[0] = fb;
        end
        return n == 32 ? s : s & ((32'h1 << n) - 1);
    endfunction
    task automatic end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        end_of_test();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, stall, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, XOR_OFF, TAP);
        apb(1'b0, XOR_OFF, 32'h0);
        chk(rd, TAP);
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, CTRL_OFF, rows[i].ctl);
            apb(1'b1, DATA_OFF, SEED);
            m.send(DIN, 32'h100 + i, rows[i].ch);
            m.idle();
            wait_dst(1);
            chk(m.got_q.pop_front(), {32'h100 + i, rows[i].dst});
            apb(1'b0, DATA_OFF, 32'h0);
            chk(rd, exp_crc(rows[i].ctl, rows[i].ch, SEED, DIN));
            apb(1'b0, ADDR_OFF, 32'h0);
            chk(rd, 32'h100 + i);
        end
        // append: no data out, one result word at the start address
        apb(1'b1, CTRL_OFF, 32'h0000_1fc5);
        apb(1'b1, DATA_OFF, SEED);
        m.send(DIN, 32'h200, 3'h5);
        m.send(~DIN, 32'h204, 3'h5);
        m.idle();
        m.blk(3'h4, 32'h3000);
        m.blk(3'h5, 32'h2000);
        e = exp_crc(32'h1fc5, 3'h5, exp_crc(32'h1fc5, 3'h5, SEED, DIN), ~DIN);
        wait_dst(1);
        repeat (5) @(posedge pclk);
        chk(64'(m.got_q.size()), 64'h1);
        chk(m.got_q.pop_front(), {32'h2000, e});
        apb(1'b1, CTRL_OFF, SEED);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(rd, 32'h3900_1fa7);
        apb(1'b1, 8'h10, SEED);
        chk({er, rd}, 33'h1_0000_0000);
        // stalled sink: 32 in fifo, one in the output stage, then refusal
        apb(1'b1, CTRL_OFF, 32'h0);
        stall <= 1'b1;
        fork
            begin
                for (int k = 0; k < 34; k++) m.send(k, 32'h400, 3'h0);
                m.idle();
            end
            begin
                repeat (45) @(posedge pclk);
                chk(sr, 1'b0);
                stall <= 1'b0;
            end
        join
        wait_dst(34);
        for (int k = 0; k < 34; k++) chk(m.got_q[k], {32'h400, 32'(k)});
        m.got_q.delete();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({sr, pready, dv}, 3'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(rd, 32'h0);
        end
        end_of_test();
    end
endmodule
